// ### hw/rpo_payload_out.sv
// package and top module of the receive payload output port
package rpo_pkg;
  // clocking
  localparam int CORE_PERIOD_NS = 5;  // core_clk period
  localparam int LINE_RATE_KHZ = 44736;  // serial output clock rate, set by the line clock
  // output clock shape: one output period is four core cycles
  localparam logic [1:0] PHASE_FIRST = 2'h0;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] SER_HIGH_LAST = 2'h1;  // serial clock high in phases 0 and 1
  localparam logic [1:0] NIB_HIGH_PHASE = 2'h3;  // nibble clock high in phase 3 only
  localparam int NIBBLES_PER_FRAME = 1176;  // payload nibbles in one frame
  // word layout across the buffer: first line bit sits in bit 3 of each field
  localparam int WORD_BITS = 4;
  localparam int WORD_W = 12;
  localparam int DATA_LSB = 0;
  localparam int OH_LSB = 4;
  localparam int SOF_LSB = 8;
  localparam logic [1:0] SLOT_FIRST = 2'h0;
  localparam logic [1:0] SLOT_LAST = 2'h3;
  localparam int BUF_DEPTH = 2;
  // reset values
  localparam logic [3:0] NIB_RESET = 4'h0;
  localparam logic [WORD_W-1:0] WORD_RESET = 12'h000;
  localparam logic [1:0] CNT_RESET = 2'h0;
  // output engine states
  typedef enum logic [0:0] {RPO_IDLE, RPO_RUN} rpo_state_t;
endpackage

// Operation
// RL1 - strap low serial, high nibble; others quiet
// RL2 - serial mode drives line-rate output clock
// RL3 - serial bit changes on output clock rise
// RL4 - nibble clock from line clock, 1176 pulses
// RL5 - nibble data changes on output clock fall
// RL6 - nibble clock high about a quarter period
// RL7 - overhead flag high exactly on overhead bits
// RL8 - overhead flag changes on rise with bit; code drops it with the clock parked low when starved
// RL9 - overhead flag low in nibble mode
// RL10 - serial frame flag one bit, first bit
// RL11 - nibble frame flag one nibble, first nibble
// RL12 - receiver samples serial data on rise
// RL13 - receiver samples flags with serial data
// RL14 - receiver drops bits flagged as overhead
// RL15 - receiver samples nibbles on rising edge
// RL16 - frame flag low at every other position
module rpo_payload_out (
  // core clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // mode strap pin
  input wire logic width_select_strap,
  // line side, from the framer on the line clock
  input wire logic rx_line_clock_in,
  input wire logic line_data_bit,
  input wire logic line_overhead_bit,
  input wire logic line_frame_first,
  output logic link_buffer_ready,
  // terminal side outputs
  output logic rx_payload_out_clock,
  output logic rx_serial_payload_out,
  output logic [3:0] rx_parallel_payload_out,
  output logic rx_overhead_bit_flag,
  output logic rx_frame_start_flag
);

  // picks slot k of a field, first line bit first
  function automatic logic pick(input logic [3:0] field, input logic [1:0] slot);
    pick = field[2'h3 - slot];
  endfunction

  // ---------------- line clock domain ----------------
  logic link_rst_s1;  // reset release synchroniser
  logic link_rst;  // link domain reset, released on the line clock
  logic lstrap_s1;  // strap sync, first stage
  logic lstrap_s2;  // strap sync, second stage
  logic [3:0] acc_data;  // bits being gathered
  logic [3:0] acc_oh;
  logic [3:0] acc_sof;
  logic [1:0] cnt;  // bits gathered so far
  logic pend;  // frame start waiting for first payload bit
  logic wr_valid;  // word offered to the buffer
  logic [rpo_pkg::WORD_W-1:0] wr_word;
  logic buf_wr_ready;
  logic [3:0] next_acc_data;
  logic [3:0] next_acc_oh;
  logic [3:0] next_acc_sof;
  logic [1:0] next_cnt;
  logic next_pend;
  logic next_wr_valid;
  logic [rpo_pkg::WORD_W-1:0] next_wr_word;

  // reset assert is immediate, release waits two line clock edges
  always_ff @(posedge rx_line_clock_in or posedge rst) begin
    if (rst) begin
      link_rst_s1 <= 1'b1;
      link_rst <= 1'b1;
    end else begin
      link_rst_s1 <= 1'b0;
      link_rst <= link_rst_s1;
    end
  end

  // strap is a pin: two flops before use
  always_ff @(posedge rx_line_clock_in or posedge link_rst) begin
    if (link_rst) begin
      lstrap_s1 <= 1'b0;
      lstrap_s2 <= 1'b0;
    end else begin
      lstrap_s1 <= width_select_strap;
      lstrap_s2 <= lstrap_s1;
    end
  end

  // packer: four line bits per word; nibble mode keeps payload bits only
  always_comb begin
    logic [1:0] base_cnt;
    logic base_pend;
    logic accept;
    logic new_sof;
    base_cnt = line_frame_first ? rpo_pkg::CNT_RESET : cnt;  // realign on frame start
    base_pend = line_frame_first | pend;
    accept = lstrap_s2 ? !line_overhead_bit : 1'b1;  // RL9
    new_sof = lstrap_s2 ? base_pend : line_frame_first;
    next_acc_data = acc_data;
    next_acc_oh = acc_oh;
    next_acc_sof = acc_sof;
    next_cnt = base_cnt;
    next_pend = base_pend;
    next_wr_word = wr_word;
    // offered word leaves once the buffer takes it
    next_wr_valid = wr_valid && !buf_wr_ready;
    if (accept) begin
      next_acc_data = {acc_data[2:0], line_data_bit};
      next_acc_oh = {acc_oh[2:0], line_overhead_bit & !lstrap_s2};  // RL7
      next_acc_sof = {acc_sof[2:0], new_sof};  // RL16
      next_pend = 1'b0;
      if (base_cnt == rpo_pkg::SLOT_LAST) begin
        // a stalled word is overwritten here; link_buffer_ready warns upstream
        next_wr_valid = 1'b1;
        next_wr_word = {next_acc_sof, next_acc_oh, next_acc_data};
        next_cnt = rpo_pkg::CNT_RESET;
      end else begin
        next_cnt = base_cnt + 2'h1;
      end
    end
  end

  // packer registers
  always_ff @(posedge rx_line_clock_in or posedge link_rst) begin
    if (link_rst) begin
      acc_data <= rpo_pkg::NIB_RESET;
      acc_oh <= rpo_pkg::NIB_RESET;
      acc_sof <= rpo_pkg::NIB_RESET;
      cnt <= rpo_pkg::CNT_RESET;
      pend <= 1'b0;
      wr_valid <= 1'b0;
      wr_word <= rpo_pkg::WORD_RESET;
    end else begin
      acc_data <= next_acc_data;
      acc_oh <= next_acc_oh;
      acc_sof <= next_acc_sof;
      cnt <= next_cnt;
      pend <= next_pend;
      wr_valid <= next_wr_valid;
      wr_word <= next_wr_word;
    end
  end

  // ---------------- crossing ----------------
  logic buf_valid;  // word waiting on the core side
  logic [rpo_pkg::WORD_W-1:0] buf_data;
  logic take;  // core engine consumes the word

  // two-entry gray-pointer buffer carries words to the core clock
  rpo_async_buf #(
    .WIDTH(rpo_pkg::WORD_W),
    .DEPTH(rpo_pkg::BUF_DEPTH)
  ) u_buf (
    .wr_clk(rx_line_clock_in),
    .wr_rst(link_rst),
    .wr_valid(wr_valid),
    .wr_data(wr_word),
    .wr_ready(buf_wr_ready),
    .rd_clk(core_clk),
    .rd_rst(rst),
    .rd_ready(take),
    .rd_valid(buf_valid),
    .rd_data(buf_data)
  );
  assign link_buffer_ready = buf_wr_ready;  // flop inside the buffer

  // ---------------- core clock domain ----------------
  logic strap_s1;  // strap sync, first stage
  logic nib_mode;  // strap sync, second stage: high selects nibble mode
  rpo_pkg::rpo_state_t state;
  logic [1:0] phase;  // core cycle within one output period
  logic [1:0] slot;  // serial bit within the word
  logic [rpo_pkg::WORD_W-1:0] word;  // word being sent
  rpo_pkg::rpo_state_t next_state;
  logic [1:0] next_phase;
  logic [1:0] next_slot;
  logic [rpo_pkg::WORD_W-1:0] next_word;
  logic next_clk;
  logic next_ser;
  logic [3:0] next_nib;
  logic next_oh;
  logic next_sof;

  // strap pin enters through two flops
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strap_s1 <= 1'b0;
      nib_mode <= 1'b0;
    end else begin
      strap_s1 <= width_select_strap;
      nib_mode <= strap_s1;  // RL1
    end
  end

  // output engine: one period per serial bit or per nibble
  always_comb begin
    logic load;
    logic advance;
    logic [rpo_pkg::WORD_W-1:0] w;
    logic [1:0] s;
    load = 1'b0;
    advance = 1'b0;
    w = word;  // current word unless a load replaces it
    s = slot;
    next_state = state;
    next_phase = phase;
    next_slot = slot;
    next_word = word;
    next_ser = rx_serial_payload_out;
    next_nib = rx_parallel_payload_out;
    next_oh = rx_overhead_bit_flag;
    next_sof = rx_frame_start_flag;
    case (state)
      rpo_pkg::RPO_IDLE: begin
        load = buf_valid;
      end
      rpo_pkg::RPO_RUN: begin
        if (phase != rpo_pkg::PHASE_LAST) begin
          next_phase = phase + 2'h1;
        end else if (!nib_mode && slot != rpo_pkg::SLOT_LAST) begin
          advance = 1'b1;  // next serial bit of the same word
        end else if (buf_valid) begin
          load = 1'b1;
        end else begin
          // starved: clock parks low, flags drop
          next_state = rpo_pkg::RPO_IDLE;
          next_phase = rpo_pkg::PHASE_FIRST;
          next_oh = 1'b0;
          next_sof = 1'b0;  // RL16
        end
      end
      default: begin
        next_state = rpo_pkg::RPO_IDLE;
      end
    endcase
    take = load;
    w = load ? buf_data : word;
    s = load ? rpo_pkg::SLOT_FIRST : slot + 2'h1;
    if (load || advance) begin
      // new position starts in phase 0: serial clock rises, nibble clock falls
      next_state = rpo_pkg::RPO_RUN;
      next_phase = rpo_pkg::PHASE_FIRST;
      next_word = w;
      next_slot = s;
      next_ser = pick(w[rpo_pkg::DATA_LSB +: rpo_pkg::WORD_BITS], s);  // RL3
      next_oh = pick(w[rpo_pkg::OH_LSB +: rpo_pkg::WORD_BITS], s);  // RL7 RL8
      next_nib = w[rpo_pkg::DATA_LSB +: rpo_pkg::WORD_BITS];  // RL5
      next_sof = nib_mode ? pick(w[rpo_pkg::SOF_LSB +: rpo_pkg::WORD_BITS], rpo_pkg::SLOT_FIRST)
                          : pick(w[rpo_pkg::SOF_LSB +: rpo_pkg::WORD_BITS], s);  // RL10 RL11
    end
    // only the selected mode's outputs carry anything
    if (nib_mode) begin
      next_ser = 1'b0;  // RL1
      next_oh = 1'b0;  // RL9
    end else begin
      next_nib = rpo_pkg::NIB_RESET;  // RL1
    end
    // clock shape follows the phase; rate follows the line words
    if (next_state == rpo_pkg::RPO_RUN) begin
      next_clk = nib_mode ? (next_phase == rpo_pkg::NIB_HIGH_PHASE)  // RL4 RL6
                          : (next_phase <= rpo_pkg::SER_HIGH_LAST);  // RL2
    end else begin
      next_clk = 1'b0;
    end
  end

  // engine and output registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= rpo_pkg::RPO_IDLE;
      phase <= rpo_pkg::PHASE_FIRST;
      slot <= rpo_pkg::SLOT_FIRST;
      word <= rpo_pkg::WORD_RESET;
      rx_payload_out_clock <= 1'b0;
      rx_serial_payload_out <= 1'b0;
      rx_parallel_payload_out <= rpo_pkg::NIB_RESET;
      rx_overhead_bit_flag <= 1'b0;
      rx_frame_start_flag <= 1'b0;
    end else begin
      state <= next_state;
      phase <= next_phase;
      slot <= next_slot;
      word <= next_word;
      rx_payload_out_clock <= next_clk;
      rx_serial_payload_out <= next_ser;
      rx_parallel_payload_out <= next_nib;
      rx_overhead_bit_flag <= next_oh;
      rx_frame_start_flag <= next_sof;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_serial_nib_quiet: assert property (!$past(nib_mode) |-> rx_parallel_payload_out == 4'h0) // RL1
    else $error("nibble outputs active in serial mode");
  a_nibble_ser_quiet: assert property ($past(nib_mode) |-> !rx_serial_payload_out) // RL1
    else $error("serial output active in nibble mode");
  a_serial_clk_shape: assert property ( // RL2
    (!nib_mode && $past(!nib_mode) && $rose(rx_payload_out_clock))
      |-> rx_payload_out_clock ##1 rx_payload_out_clock ##1 !rx_payload_out_clock)
    else $error("serial clock not high for two cycles");
  a_serial_bit_edge: assert property ( // RL3
    (!nib_mode && !$past(nib_mode) && $changed(rx_serial_payload_out))
      |-> $rose(rx_payload_out_clock))
    else $error("serial bit changed off the rising edge");
  a_nibble_duty: assert property ( // RL6
    (nib_mode && $past(nib_mode) && $rose(rx_payload_out_clock))
      |=> !rx_payload_out_clock [*3])
    else $error("nibble clock high too long");
  a_nibble_data_edge: assert property ( // RL5
    (nib_mode && $past(nib_mode) && $changed(rx_parallel_payload_out))
      |-> !rx_payload_out_clock && phase == 2'h0)
    else $error("nibble data changed off the falling edge");
  a_overhead_nib_low: assert property ($past(nib_mode) |-> !rx_overhead_bit_flag) // RL9
    else $error("overhead flag high in nibble mode");
  a_overhead_on_rise: assert property ( // RL8
    $rose(rx_overhead_bit_flag) |-> $rose(rx_payload_out_clock) && !nib_mode)
    else $error("overhead flag rose off the clock rise");
  a_serial_frame_bit: assert property ( // RL10
    (!nib_mode && !$past(nib_mode) && $rose(rx_frame_start_flag))
      |-> $rose(rx_payload_out_clock) ##4 (!rx_frame_start_flag || $rose(rx_payload_out_clock)))
    else $error("serial frame flag not one bit period");
  a_frame_idle_low: assert property ((state == rpo_pkg::RPO_IDLE) |-> !rx_frame_start_flag) // RL16
    else $error("frame flag high with no position on the port");

endmodule // rpo_payload_out

// ### hw/rpo_async_buf.sv
// two-clock word buffer with gray-coded pointers and registered read data
module rpo_async_buf #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 2
) (
  // filling side
  input wire logic wr_clk,
  input wire logic wr_rst,
  input wire logic wr_valid,
  input wire logic [WIDTH-1:0] wr_data,
  output logic wr_ready,
  // draining side
  input wire logic rd_clk,
  input wire logic rd_rst,
  input wire logic rd_ready,
  output logic rd_valid,
  output logic [WIDTH-1:0] rd_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;  // address width
  localparam int PW = AW + 1;  // pointer width with wrap bit
  localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);

  // binary to gray
  function automatic logic [PW-1:0] to_gray(input logic [PW-1:0] b);
    to_gray = b ^ (b >> 1);
  endfunction

  // gray to binary
  function automatic logic [PW-1:0] to_bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = g;
    for (int i = PW - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    to_bin = b;
  endfunction

  logic [WIDTH-1:0] mem [DEPTH];  // storage, written on wr_clk only
  logic [PW-1:0] wbin;  // write pointer
  logic [PW-1:0] wgray;
  logic [PW-1:0] rgray_s1;  // read pointer sync, first stage
  logic [PW-1:0] rgray_s2;
  logic [PW-1:0] rbin;  // read pointer
  logic [PW-1:0] rgray;
  logic [PW-1:0] wgray_s1;  // write pointer sync, first stage
  logic [PW-1:0] wgray_s2;
  logic push;
  logic load;
  logic [PW-1:0] next_wbin;
  logic next_wr_ready;
  logic [PW-1:0] next_rbin;
  logic next_rd_valid;

  // write side: ready is pessimistic while the read pointer is in flight
  always_comb begin
    push = wr_valid && wr_ready;
    next_wbin = wbin + PW'(push);
    next_wr_ready = (next_wbin - to_bin(rgray_s2)) != DEPTH_P;
  end

  // write side registers
  always_ff @(posedge wr_clk or posedge wr_rst) begin
    if (wr_rst) begin
      wbin <= '0;
      wgray <= '0;
      rgray_s1 <= '0;
      rgray_s2 <= '0;
      wr_ready <= 1'b0;
    end else begin
      wbin <= next_wbin;
      wgray <= to_gray(next_wbin);
      rgray_s1 <= rgray;
      rgray_s2 <= rgray_s1;
      wr_ready <= next_wr_ready;
    end
  end

  // storage write, no reset needed on data
  always_ff @(posedge wr_clk) begin
    if (push) begin
      mem[wbin[AW-1:0]] <= wr_data;
    end
  end

  // read side: output register refills whenever it empties or is taken
  always_comb begin
    load = (!rd_valid || rd_ready) && (rbin != to_bin(wgray_s2));
    next_rbin = rbin + PW'(load);
    next_rd_valid = load || (rd_valid && !rd_ready);
  end

  // read side registers
  always_ff @(posedge rd_clk or posedge rd_rst) begin
    if (rd_rst) begin
      rbin <= '0;
      rgray <= '0;
      wgray_s1 <= '0;
      wgray_s2 <= '0;
      rd_valid <= 1'b0;
      rd_data <= '0;
    end else begin
      rbin <= next_rbin;
      rgray <= to_gray(next_rbin);
      wgray_s1 <= wgray;
      wgray_s2 <= wgray_s1;
      rd_valid <= next_rd_valid;
      if (load) begin
        rd_data <= mem[rbin[AW-1:0]];
      end
    end
  end

endmodule // rpo_async_buf

// ### verif/rpo_term_model.sv
// terminal equipment model that captures the receive payload port
module rpo_term_model (
  // outputs of the payload port
  input wire logic rx_payload_out_clock,
  input wire logic rx_serial_payload_out,
  input wire logic [3:0] rx_parallel_payload_out,
  input wire logic rx_overhead_bit_flag,
  input wire logic rx_frame_start_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [6:0] cap_q[$]; // {sof, oh, serial, nibble} per rising edge
  logic pay_q[$]; // serial payload with overhead removed
  realtime rise_t = 0; // time of the last rise
  realtime hi_ns = 0; // width of the last high phase

  // capture on the rise; in serial mode rtl launches data with the rise, so settle first
  always @(posedge rx_payload_out_clock) begin
    rise_t = $realtime;
    #1;
    cap_q.push_back({rx_frame_start_flag, rx_overhead_bit_flag, rx_serial_payload_out,
      rx_parallel_payload_out});
    // overhead bits are not payload
    if (rx_overhead_bit_flag === 1'b0) begin
      pay_q.push_back(rx_serial_payload_out);
    end
  end

  // high width gives the duty cycle
  always @(negedge rx_payload_out_clock) begin
    hi_ns = $realtime - rise_t;
  end
endmodule // rpo_term_model

// ### verif/tb_top.sv
// testbench for the receive payload output port
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // clocks, reset, strap
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic width_select_strap = 1'b0;
  logic rx_line_clock_in = 1'b0;
  int line_gap = 1; // line slots per bit; serial drain is slower than 6 ns
  // line side stimulus
  logic line_data_bit = 1'b0;
  logic line_overhead_bit = 1'b0;
  logic line_frame_first = 1'b0;
  logic link_buffer_ready;
  // terminal side
  logic rx_payload_out_clock;
  logic rx_serial_payload_out;
  logic [3:0] rx_parallel_payload_out;
  logic rx_overhead_bit_flag;
  logic rx_frame_start_flag;
  logic [2:0] line_q[$]; // {first, oh, bit} waiting for the line
  logic [2:0] sent[$]; // copy of what was offered
  int miscompares = 0;
  int num_checks = 0;

  rpo_payload_out u_rpo_payload_out (
    .core_clk(core_clk), .rst(rst), .width_select_strap(width_select_strap),
    .rx_line_clock_in(rx_line_clock_in), .line_data_bit(line_data_bit),
    .line_overhead_bit(line_overhead_bit), .line_frame_first(line_frame_first),
    .link_buffer_ready(link_buffer_ready), .rx_payload_out_clock(rx_payload_out_clock),
    .rx_serial_payload_out(rx_serial_payload_out),
    .rx_parallel_payload_out(rx_parallel_payload_out),
    .rx_overhead_bit_flag(rx_overhead_bit_flag), .rx_frame_start_flag(rx_frame_start_flag));

  rpo_term_model u_rpo_term_model (
    .rx_payload_out_clock(rx_payload_out_clock),
    .rx_serial_payload_out(rx_serial_payload_out),
    .rx_parallel_payload_out(rx_parallel_payload_out),
    .rx_overhead_bit_flag(rx_overhead_bit_flag), .rx_frame_start_flag(rx_frame_start_flag));

  // core clock, 5 ns
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  // line clock, 6 ns cycles, offset phase, gapped to slow the feed
  initial begin
    #1.3;
    forever begin
      #3 rx_line_clock_in = 1'b1;
      #3 rx_line_clock_in = 1'b0;
      repeat (line_gap - 1) #6;
    end
  end

  // one line bit after each line rise; zeros when nothing queued
  always @(posedge rx_line_clock_in) begin
    #1;
    if (line_q.size() > 0) begin
      {line_frame_first, line_overhead_bit, line_data_bit} = line_q.pop_front();
    end else begin
      {line_frame_first, line_overhead_bit, line_data_bit} = 3'h0;
    end
  end

  // compare helpers
  task automatic check_bit(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic check_nib(input logic [3:0] got, input logic [3:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_num(input int got, input int exp, input string what);
    num_checks++;
    if (got != exp) begin
      miscompares++;
      $display("Error at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask

  // verdict and end of run
  task automatic print_verdict();
    $display("checks %0d, miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // bounded wait for captured periods
  task automatic wait_caps(input int n);
    int i;
    for (i = 0; i < 40000 && u_rpo_term_model.cap_q.size() < n; i++) begin
      @(posedge core_clk);
    end
    if (u_rpo_term_model.cap_q.size() < n) begin
      miscompares++;
      $display("Error at %0t: timeout waiting for output periods", $time);
      print_verdict();
    end
  endtask

  // reset with the strap settled; line already at the scenario's rate,
  // so no backlog of idle words builds up ahead of the frame
  task automatic do_reset(input logic strap, input int gap);
    @(posedge core_clk);
    #1;
    rst = 1'b1;
    line_gap = gap;
    width_select_strap = strap;
    repeat (16) @(posedge core_clk);
    check_bit(rx_payload_out_clock, 1'b0, "clock in reset");
    check_bit(link_buffer_ready, 1'b0, "ready in reset");
    check_bit(rx_frame_start_flag, 1'b0, "sof in reset");
    #1 rst = 1'b0;
    repeat (20) @(posedge core_clk);
    u_rpo_term_model.cap_q.delete();
    u_rpo_term_model.pay_q.delete();
    line_q.delete();
  endtask

  // first of the first 60 captured periods carrying the frame flag, -1 if none there
  function automatic int find_sof();
    int i;
    for (i = 0; i < 60 && i < u_rpo_term_model.cap_q.size(); i++) begin
      if (u_rpo_term_model.cap_q[i][6] === 1'b1) begin
        return i;
      end
    end
    return -1;
  endfunction

  // serial: two short frames, overhead every 12th bit
  task automatic test_serial();
    int base;
    int i;
    int j;
    logic [6:0] c;
    do_reset(1'b0, 4);
    for (i = 0; i < 48; i++) begin
      line_q.push_back({i % 24 == 0, i % 12 == 0, ((i * 5) % 7) < 3});
    end
    sent = line_q;
    wait_caps(70);
    base = find_sof();
    check_num(int'(base >= 0), 1, "serial frame flag seen");
    wait_caps(base + 48);
    j = 0;
    for (i = 0; i < 48 && base >= 0; i++) begin
      c = u_rpo_term_model.cap_q[base + i];
      check_bit(c[4], sent[i][0], "serial bit");
      check_bit(c[5], sent[i][1], "overhead flag");
      check_bit(c[6], sent[i][2], "serial frame flag");
      check_nib(c[3:0], 4'h0, "nibble quiet in serial");
      // idle bits ahead of the frame carry no overhead, so indices line up
      if (sent[i][1] === 1'b0) begin
        check_bit(u_rpo_term_model.pay_q[base + j], sent[i][0], "payload bit");
        j++;
      end
    end
    check_num(int'(u_rpo_term_model.hi_ns), 2 * rpo_pkg::CORE_PERIOD_NS, "serial high");
    check_bit(link_buffer_ready, 1'b1, "ready in serial");
  endtask

  // nibble: a full frame, overhead every 85th bit, then the next frame start
  task automatic test_nibble();
    int base;
    int i;
    int k;
    logic [3:0] e;
    logic pay[$];
    logic [6:0] c;
    do_reset(1'b1, 1);
    for (i = 0; i < 2 * 4760; i++) begin
      line_q.push_back({i % 4760 == 0, i % 85 == 0, ((i * 5) % 7) < 3});
      if (i % 85 != 0) begin
        pay.push_back(((i * 5) % 7) < 3);
      end
    end
    wait_caps(1200);
    base = find_sof();
    check_num(int'(base >= 0), 1, "nibble frame flag seen");
    wait_caps(base + 1177);
    for (k = 0; k < 1176 && base >= 0; k++) begin
      c = u_rpo_term_model.cap_q[base + k];
      e = {pay[4 * k], pay[4 * k + 1], pay[4 * k + 2], pay[4 * k + 3]};
      check_nib(c[3:0], e, "nibble");
      check_bit(c[6], k == 0, "nibble frame flag");
      check_bit(c[5], 1'b0, "overhead flag in nibble");
      check_bit(c[4], 1'b0, "serial quiet in nibble");
    end
    c = u_rpo_term_model.cap_q[base + 1176];
    check_bit(c[6], 1'b1, "next frame after 1176 pulses");
    check_num(int'(u_rpo_term_model.hi_ns), rpo_pkg::CORE_PERIOD_NS, "nibble high");
    check_bit(link_buffer_ready, 1'b1, "ready in nibble");
  endtask

  // main sequence
  initial begin
    test_serial();
    test_nibble();
    print_verdict();
  end
endmodule // tb_top
